// ===== core/rel_pkg.sv
// package: register map, field positions, timing constants and carriers for the event latches
package rel_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_EVENT_FLAGS_OFS = 8'h1A;
  localparam logic [7:0] BUCK_EVENT_FLAGS_OFS = 8'h1B;
  localparam logic [7:0] LINEAR_REG_EVENT_FLAGS_OFS = 8'h1C;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_EVENT_FLAGS_RST = 8'h00;
  localparam logic [7:0] BUCK_EVENT_FLAGS_RST = 8'h00;
  localparam logic [7:0] LINEAR_REG_EVENT_FLAGS_RST = 8'h00;
  localparam int RESET_EVENT_BIT = 0;
  localparam logic [7:0] RESET_EVENT_MASK = 8'h01;
  // layout shared by both regulator pairs: bits 6..4 second, 2..0 first
  localparam int SECOND_PG_BIT = 6;
  localparam int SECOND_SC_BIT = 5;
  localparam int SECOND_ILIM_BIT = 4;
  localparam int FIRST_PG_BIT = 2;
  localparam int FIRST_SC_BIT = 1;
  localparam int FIRST_ILIM_BIT = 0;
  localparam logic [7:0] EVENT_MASK = 8'h77;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHORT_TIME_MS = 1;
  localparam int SHORT_CYCLES = (SHORT_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int SHORT_CNT_W = 17;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic powergood_event;
    logic short_below;
    logic curlimit_active;
  } rel_reg_cond_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rel_reg_req_t;

endpackage

// ===== core/rel_short_timer.sv
// module: qualifies a below-short-circuit level that persists longer than the set time
`timescale 1ns/100ps
module rel_short_timer #(
  parameter int SHORT_LIMIT = rel_pkg::SHORT_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sync_clear_i,
  // condition in, qualified pulse out
  input wire logic below_i,
  output logic expired_o
);

  logic [rel_pkg::SHORT_CNT_W-1:0] count_ff;
  logic [rel_pkg::SHORT_CNT_W-1:0] nxt_count;
  logic fired_ff;
  logic nxt_fired;
  logic [rel_pkg::SHORT_CNT_W-1:0] limit;

  assign limit = rel_pkg::SHORT_CNT_W'(SHORT_LIMIT);

  always_comb begin
    nxt_count = count_ff;
    nxt_fired = fired_ff;
    expired_o = 1'b0;
    if (sync_clear_i || !below_i) begin
      nxt_count = '0;
      nxt_fired = 1'b0;
    end else if (count_ff < limit) begin
      nxt_count = count_ff + rel_pkg::SHORT_CNT_W'(1);
    end else if (!fired_ff) begin
      // strictly more than the limit: one pulse per continuous episode
      expired_o = 1'b1;
      nxt_fired = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_ff <= '0;
      fired_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      fired_ff <= nxt_fired;
    end
  end

endmodule // rel_short_timer

// ===== core/rel_event_latches.sv
// module: sticky supply-event status registers with write-one-to-clear access
`timescale 1ns/100ps

// Functional notes
// - A supply undervoltage or a software reset request sets reset-event flag bit 0.
// - A reset event disables all regulators, restores register defaults, then starts up again.
// - Writing 1 to bit 0 of the reset-event register clears the reset-event flag.
// - A second buck power-good event latches buck event bit 6.
// - Second buck output below short threshold for over 1 ms latches buck event bit 5.
// - Second buck current limit being active latches buck event bit 4.
// - A first buck power-good event latches buck event bit 2.
// - First buck output below short threshold for over 1 ms latches buck event bit 1.
// - First buck current limit being active latches buck event bit 0.
// - Buck event bits clear on a written 1 or a register-defaults restore; a written 0 leaves them alone.
// - A second linear regulator power-good event latches linear event bit 6, cleared by a 1.
// - Second linear regulator below short threshold for over 1 ms latches linear event bit 5.
// - The buck-pending summary reads set while any buck event bit is set.
// - The linear-pending summary reads set while any linear event bit is set.
module rel_event_latches #(
  parameter int SHORT_LIMIT = rel_pkg::SHORT_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // register access from the serial bus engine
  input wire rel_pkg::rel_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // supply conditions
  input wire logic analog_supply_low_i,
  input wire logic software_reset_request_i,
  input wire rel_pkg::rel_reg_cond_t first_buck_i,
  input wire rel_pkg::rel_reg_cond_t second_buck_i,
  input wire rel_pkg::rel_reg_cond_t first_linreg_i,
  input wire rel_pkg::rel_reg_cond_t second_linreg_i,
  // control outputs
  output logic regulators_disable_o,
  output logic register_defaults_o,
  output logic startup_restart_o,
  output logic buck_pending_summary_o,
  output logic linreg_pending_summary_o
);

  // ----------------------------------------------------------------
  // reset-event sequencing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    REL_RUN = 3'b001,
    REL_DISABLE = 3'b010,
    REL_DEFAULTS = 3'b100
  } rel_seq_t;

  rel_seq_t seq_ff;
  rel_seq_t nxt_seq;
  logic reset_event;
  logic restore;

  assign reset_event = analog_supply_low_i || software_reset_request_i;

  always_comb begin
    nxt_seq = seq_ff;
    restore = 1'b0;
    case (seq_ff)
      REL_RUN: begin
        if (reset_event) begin
          nxt_seq = REL_DISABLE;
        end
      end
      // regulators stay off for as long as the cause persists
      REL_DISABLE: begin
        if (!reset_event) begin
          nxt_seq = REL_DEFAULTS;
        end
      end
      // a cause already back during the restore cycle must not slip through to run
      REL_DEFAULTS: begin
        restore = 1'b1;
        if (reset_event) begin
          nxt_seq = REL_DISABLE;
        end else begin
          nxt_seq = REL_RUN;
        end
      end
      default: begin
        nxt_seq = REL_DISABLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_ff <= REL_RUN;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  assign regulators_disable_o = (seq_ff != REL_RUN);
  assign register_defaults_o = restore;
  assign startup_restart_o = restore;

  // ----------------------------------------------------------------
  // short-circuit qualification
  // ----------------------------------------------------------------
  function automatic logic [7:0] event_vector(input rel_pkg::rel_reg_cond_t second_c,
                                              input rel_pkg::rel_reg_cond_t first_c,
                                              input logic second_short,
                                              input logic first_short);
    logic [7:0] v;
    v = 8'h00;
    v[rel_pkg::SECOND_PG_BIT] = second_c.powergood_event;
    v[rel_pkg::SECOND_SC_BIT] = second_short;
    v[rel_pkg::SECOND_ILIM_BIT] = second_c.curlimit_active;
    v[rel_pkg::FIRST_PG_BIT] = first_c.powergood_event;
    v[rel_pkg::FIRST_SC_BIT] = first_short;
    v[rel_pkg::FIRST_ILIM_BIT] = first_c.curlimit_active;
    return v;
  endfunction

  // set wins over clear; reserved positions are masked out of both
  function automatic logic [7:0] w1c_next(input logic [7:0] cur,
                                          input logic [7:0] set,
                                          input logic [7:0] clr,
                                          input logic [7:0] mask);
    return ((cur & ~clr) | set) & mask;
  endfunction

  logic [3:0] short_expired;
  logic [3:0] short_below;

  assign short_below = {second_linreg_i.short_below, first_linreg_i.short_below,
                        second_buck_i.short_below, first_buck_i.short_below};

  // timers restart with the register defaults so no stale count survives a reset event
  for (genvar g = 0; g < 4; g++) begin : g_short
    rel_short_timer #(
      .SHORT_LIMIT(SHORT_LIMIT)
    ) u_short (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .sync_clear_i(restore),
      .below_i(short_below[g]),
      .expired_o(short_expired[g])
    );
  end

  // ----------------------------------------------------------------
  // event registers
  // ----------------------------------------------------------------
  logic [7:0] reset_flags_ff;
  logic [7:0] buck_flags_ff;
  logic [7:0] linreg_flags_ff;
  logic [7:0] nxt_reset_flags;
  logic [7:0] nxt_buck_flags;
  logic [7:0] nxt_linreg_flags;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] buck_set;
  logic [7:0] linreg_set;
  logic [7:0] clr_reset;
  logic [7:0] clr_buck;
  logic [7:0] clr_linreg;

  assign buck_set = event_vector(second_buck_i, first_buck_i,
                                 short_expired[1], short_expired[0]);
  assign linreg_set = event_vector(second_linreg_i, first_linreg_i,
                                   short_expired[3], short_expired[2]);

  always_comb begin
    clr_reset = 8'h00;
    clr_buck = 8'h00;
    clr_linreg = 8'h00;
    if (reg_req_i.wr_en && reg_req_i.addr == rel_pkg::RESET_EVENT_FLAGS_OFS) begin
      clr_reset = reg_req_i.wdata;
    end else if (reg_req_i.wr_en && reg_req_i.addr == rel_pkg::BUCK_EVENT_FLAGS_OFS) begin
      clr_buck = reg_req_i.wdata;
    end else if (reg_req_i.wr_en && reg_req_i.addr == rel_pkg::LINEAR_REG_EVENT_FLAGS_OFS) begin
      clr_linreg = reg_req_i.wdata;
    end
  end

  always_comb begin
    nxt_reset_flags = w1c_next(reset_flags_ff, {7'h00, reset_event}, clr_reset,
                               rel_pkg::RESET_EVENT_MASK);
    nxt_buck_flags = w1c_next(buck_flags_ff, buck_set, clr_buck,
                              rel_pkg::EVENT_MASK);
    nxt_linreg_flags = w1c_next(linreg_flags_ff, linreg_set, clr_linreg,
                                rel_pkg::EVENT_MASK);
    if (restore) begin
      // defaults restored, but the reset event itself stays recorded
      nxt_reset_flags = rel_pkg::RESET_EVENT_MASK;
      nxt_buck_flags = rel_pkg::BUCK_EVENT_FLAGS_RST;
      nxt_linreg_flags = rel_pkg::LINEAR_REG_EVENT_FLAGS_RST;
    end
    if (reg_req_i.rd_en && reg_req_i.addr == rel_pkg::RESET_EVENT_FLAGS_OFS) begin
      nxt_rdata = reset_flags_ff;
    end else if (reg_req_i.rd_en && reg_req_i.addr == rel_pkg::BUCK_EVENT_FLAGS_OFS) begin
      nxt_rdata = buck_flags_ff;
    end else if (reg_req_i.rd_en && reg_req_i.addr == rel_pkg::LINEAR_REG_EVENT_FLAGS_OFS) begin
      nxt_rdata = linreg_flags_ff;
    end else if (reg_req_i.rd_en) begin
      nxt_rdata = rel_pkg::READ_UNMAPPED;
    end else begin
      nxt_rdata = rdata_ff;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_flags_ff <= rel_pkg::RESET_EVENT_FLAGS_RST;
      buck_flags_ff <= rel_pkg::BUCK_EVENT_FLAGS_RST;
      linreg_flags_ff <= rel_pkg::LINEAR_REG_EVENT_FLAGS_RST;
      rdata_ff <= rel_pkg::READ_UNMAPPED;
    end else begin
      reset_flags_ff <= nxt_reset_flags;
      buck_flags_ff <= nxt_buck_flags;
      linreg_flags_ff <= nxt_linreg_flags;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = rdata_ff;
  assign buck_pending_summary_o = |buck_flags_ff;
  assign linreg_pending_summary_o = |linreg_flags_ff;

endmodule // rel_event_latches

// ===== verification/rel_host_model.sv
// partner: host side of the register path, one byte per request
`timescale 1ns/100ps
module rel_host_model (
  // clock and read data
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  // request to the block
  output rel_pkg::rel_reg_req_t req_o
);
  initial req_o = '0;
  // launched on a falling edge, taken at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    req_o = '{1'b1, 1'b0, a, d};
    @(negedge clock_i);
    req_o = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    req_o = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock_i);
    req_o = '0;
    d = rdata_i;
  endtask
endmodule // rel_host_model

// ===== verification/rel_event_latches_chk.sv
// checker: timing relations of the event latches at their ports
`timescale 1ns/100ps
module rel_event_latches_chk #(
  parameter int SHORT_LIMIT = rel_pkg::SHORT_CYCLES
) (
  // clock, reset, bus
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire rel_pkg::rel_reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  // conditions
  input wire logic analog_supply_low_i,
  input wire logic software_reset_request_i,
  input wire rel_pkg::rel_reg_cond_t first_buck_i,
  input wire rel_pkg::rel_reg_cond_t second_buck_i,
  input wire rel_pkg::rel_reg_cond_t first_linreg_i,
  input wire rel_pkg::rel_reg_cond_t second_linreg_i,
  // outputs
  input wire logic regulators_disable_o,
  input wire logic register_defaults_o,
  input wire logic startup_restart_o,
  input wire logic buck_pending_summary_o,
  input wire logic linreg_pending_summary_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // calm: no reset sequence can override a set
  logic calm;
  logic [16:0] run_ff, nxt_run;
  assign calm = !(regulators_disable_o | register_defaults_o | analog_supply_low_i
    | software_reset_request_i);
  // a restore restarts the short timers, so the reference run restarts with them
  always_comb nxt_run = (first_buck_i.short_below && !register_defaults_o) ?
    run_ff + 17'h00001 : 17'h00000;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_ff <= 17'h00000;
    end else begin
      run_ff <= nxt_run;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  rst_disable_a: assert property (analog_supply_low_i || software_reset_request_i
    |=> regulators_disable_o) else $error("no disable after reset cause");
  restore_order_a: assert property ($fell(regulators_disable_o) |->
    $past(register_defaults_o) && $past(startup_restart_o)) else $error("no restore pulse");
  defaults_clr_a: assert property (register_defaults_o |=>
    !buck_pending_summary_o && !linreg_pending_summary_o) else $error("flags kept");
  buck_set_a: assert property (calm && (first_buck_i.powergood_event
    || first_buck_i.curlimit_active || second_buck_i.powergood_event
    || second_buck_i.curlimit_active) |=> buck_pending_summary_o) else $error("no latch");
  sticky_bit_a: assert property (calm && buck_pending_summary_o &&
    !(reg_req_i.wr_en && reg_req_i.wdata != 8'h00) |=> buck_pending_summary_o)
    else $error("flag lost");
  short_fire_a: assert property (calm && $past(calm) && int'(run_ff) == SHORT_LIMIT + 1
    |-> buck_pending_summary_o) else $error("short not latched");
  rd_summary_a: assert property (reg_req_i.rd_en && reg_req_i.addr == 8'h1B
    |=> (reg_rdata_o != 8'h00) == $past(buck_pending_summary_o)) else $error("summary off");
  rd_unmapped_a: assert property (reg_req_i.rd_en && (reg_req_i.addr < 8'h1A
    || reg_req_i.addr > 8'h1C) |=> reg_rdata_o == 8'h00) else $error("unmapped data");
  cover property (register_defaults_o);
  cover property (calm && int'(run_ff) == SHORT_LIMIT + 1);
  cover property (reg_req_i.wr_en && buck_pending_summary_o);
endmodule // rel_event_latches_chk
bind rel_event_latches rel_event_latches_chk #(.SHORT_LIMIT(SHORT_LIMIT)) chk (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o),
  .analog_supply_low_i(analog_supply_low_i),
  .software_reset_request_i(software_reset_request_i),
  .first_buck_i(first_buck_i),
  .second_buck_i(second_buck_i),
  .first_linreg_i(first_linreg_i),
  .second_linreg_i(second_linreg_i),
  .regulators_disable_o(regulators_disable_o),
  .register_defaults_o(register_defaults_o),
  .startup_restart_o(startup_restart_o),
  .buck_pending_summary_o(buck_pending_summary_o),
  .linreg_pending_summary_o(linreg_pending_summary_o)
);

// ===== verification/regulator_event_latches_test.sv
// testbench: event latches driven through the host model
`timescale 1ns/100ps
module regulator_event_latches_test;
  localparam int SL = 20;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic analog_supply_low_i = 1'b0;
  logic software_reset_request_i = 1'b0;
  rel_pkg::rel_reg_cond_t cnd [4] = '{default: '0};
  rel_pkg::rel_reg_req_t reg_req_i;
  logic [7:0] reg_rdata_o, v, ofs, m;
  logic regulators_disable_o, register_defaults_o, startup_restart_o;
  logic buck_pending_summary_o, linreg_pending_summary_o;
  int n_errors = 0;
  int samples_checked = 0;
  always #5 clock_i = ~clock_i;
  // short count shortened so the run stays brief
  rel_event_latches #(.SHORT_LIMIT(SL)) dut (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o),
    .analog_supply_low_i(analog_supply_low_i),
    .software_reset_request_i(software_reset_request_i),
    .first_buck_i(cnd[0]),
    .second_buck_i(cnd[1]),
    .first_linreg_i(cnd[2]),
    .second_linreg_i(cnd[3]),
    .regulators_disable_o(regulators_disable_o),
    .register_defaults_o(register_defaults_o),
    .startup_restart_o(startup_restart_o),
    .buck_pending_summary_o(buck_pending_summary_o),
    .linreg_pending_summary_o(linreg_pending_summary_o)
  );
  rel_host_model host (.clock_i(clock_i), .rdata_i(reg_rdata_o), .req_o(reg_req_i));
  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_defaults();
    for (int a = 8'h19; a <= 8'h1D; a++) begin
      host.rd(8'(a), v);
      cmp(v, 8'h00);
    end
    $display("test defaults done");
  endtask
  task automatic t_latch();
    for (int k = 0; k < 4; k++) begin
      for (int f = 0; f < 2; f++) begin
        ofs = k < 2 ? 8'h1B : 8'h1C;
        m = 8'h01 << ((k % 2) * 4 + f * 2);
        @(negedge clock_i);
        cnd[k] = f ? 3'b100 : 3'b001;
        @(negedge clock_i);
        cnd[k] = 3'b000;
        host.rd(ofs, v);
        cmp(v, m);
        cmp({7'h00, k < 2 ? buck_pending_summary_o : linreg_pending_summary_o}, 8'h01);
        host.wr(ofs, ~m);
        host.rd(ofs, v);
        cmp(v, m);
        host.wr(ofs, m);
        host.rd(ofs, v);
        cmp(v, 8'h00);
        cmp({6'h00, buck_pending_summary_o, linreg_pending_summary_o}, 8'h00);
      end
    end
    $display("test latch done");
  endtask
  task automatic t_short();
    for (int k = 0; k < 4; k++) begin
      // exactly the limit must not latch, one cycle more must
      for (int n = SL; n <= SL + 1; n++) begin
        ofs = k < 2 ? 8'h1B : 8'h1C;
        @(negedge clock_i);
        cnd[k] = 3'b010;
        repeat (n) @(negedge clock_i);
        cnd[k] = 3'b000;
        host.rd(ofs, v);
        cmp(v, n > SL ? 8'h02 << ((k % 2) * 4) : 8'h00);
        host.wr(ofs, 8'hFF);
      end
    end
    $display("test short done");
  endtask
  task automatic wait_restore();
    for (int i = 0; i < 8; i++) begin
      @(negedge clock_i);
      if (register_defaults_o === 1'b1) begin
        cmp({7'h00, startup_restart_o}, 8'h01);
        @(negedge clock_i);
        cmp({6'h00, regulators_disable_o, register_defaults_o}, 8'h00);
        return;
      end
    end
    n_errors++;
    $display("CHECK FAILED %0t no restore pulse", $time);
    final_report();
  endtask
  task automatic t_reset();
    for (int c = 0; c < 2; c++) begin
      @(negedge clock_i);
      cnd[1] = 3'b001;
      @(negedge clock_i);
      cnd[1] = 3'b000;
      analog_supply_low_i = (c == 0);
      software_reset_request_i = (c == 1);
      repeat (3) @(negedge clock_i);
      cmp({7'h00, regulators_disable_o}, 8'h01);
      analog_supply_low_i = 1'b0;
      software_reset_request_i = 1'b0;
      wait_restore();
      host.rd(8'h1B, v);
      cmp(v, 8'h00);
      host.rd(8'h1A, v);
      cmp(v, 8'h01);
      host.wr(8'h1A, 8'h01);
      host.rd(8'h1A, v);
      cmp(v, 8'h00);
    end
    $display("test reset done");
  endtask
  initial begin
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_defaults();
    t_latch();
    t_short();
    t_reset();
    final_report();
  end
endmodule // regulator_event_latches_test
